// file: logic/sdmc_core.sv
// SDRAM mode register, command decoder, burst sequencer and data lanes
//
// Summary of operation
// - Latency codes 1,2,3 select one to three clocks
// - Order bit picks sequential or interleaved bursts
// - Column order from length, type, start column
// - Upper column bits pick block, lower start
// - Bursts wrap inside their own block
// - Full page covers row, sequential only
// - Length one: exact column, order bit ignored
// - Read drives at n+m-1, valid by n+m
// - Only zero operating mode bits run normally
// - Write single bit makes writes single access
// - Nop, activate, read, write strobe encodings
// - Terminate, precharge, refresh, load mode encodings
// - Activate takes row and bank select
// - Read/write take column, bank, auto precharge
// - Precharge one bank, or all when high
// - Refresh with gate low enters self refresh
// - Refresh uses internal counter, ignores inputs
// - Load mode stores address bits
// - Byte masks per lane, write now, read later
// - High mask inhibits write or floats lane
// - Mode fields: length, type, latency, mode, write
// - Chip select high registers no command
module sdmc_core import sdmc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Command pins
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [ROW_W-1:0] addr_i,
  input wire logic bank_select_lo_i,
  input wire logic bank_select_hi_i,
  // Data pins
  input wire logic [LANES-1:0] dqm_i,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic [LANES-1:0] dq_oe_n_o,
  // Array side
  input wire logic array_hold_i,
  output logic wr_drop_o,
  // Decoded events and state
  output logic [MODE_W-1:0] mode_register_o,
  output logic act_o,
  output logic [BANK_W-1:0] act_bank_o,
  output logic [ROW_W-1:0] act_row_o,
  output logic pre_o,
  output logic [3:0] pre_banks_o,
  output logic [3:0] bank_open_o,
  output logic refresh_o,
  output logic [ROW_W-1:0] refresh_row_o,
  output logic self_refresh_o
);
  sdmc_pwr_t pwr;
  sdmc_cmd_t cmd;
  logic [MODE_W-1:0] mode_register;
  logic [2:0] burst_len_field;
  logic [2:0] latency_field;
  logic burst_order_bit;
  logic op_mode_bit_lo;
  logic op_mode_bit_hi;
  logic write_single_bit;
  logic mode_ok;
  logic [7:0] burst_count;
  logic [7:0] start_mask;
  logic [BANK_W-1:0] bank_sel;
  logic selected;
  logic run;
  logic go_act;
  logic go_rd;
  logic go_wr;
  logic go_rw;
  logic go_bst;
  logic go_pre;
  logic go_ref;
  logic go_self;
  logic go_lmr;
  logic bst_active;
  logic bst_write;
  logic bst_il;
  logic bst_ap;
  logic [BANK_W-1:0] bst_bank;
  logic [7:0] bst_base;
  logic [7:0] bst_cnt;
  logic [7:0] bst_mask;
  logic burst_end;
  logic beat_v;
  logic beat_wr;
  logic [BANK_W-1:0] beat_bank;
  logic [7:0] beat_col;
  logic ap_close;
  logic [BANK_W-1:0] ap_bank;
  logic [3:0] bank_open;
  logic [3:0] next_bank_open;
  logic fifo_ready;
  logic fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;
  logic fifo_pop;
  logic [DQ_W-1:0] mem [2**MEM_AW];
  logic rd1_v;
  logic rd2_v;
  logic [MEM_AW-1:0] rd1_a;
  logic [MEM_AW-1:0] rd2_a;
  logic sel_v;
  logic [MEM_AW-1:0] sel_a;
  logic out_v;
  logic [LANES-1:0] dqm_q;

  // Wrap inside block
  // Column of beat k inside the block given by mask
  function automatic logic [7:0] burst_col(input logic [7:0] base, input logic [7:0] k,
                                           input logic [7:0] mask, input logic il);
    logic [7:0] step;
    step = il ? (base ^ k) : 8'(base + k);
    return (base & ~mask) | (step & mask);
  endfunction

  assign burst_len_field = mode_register[BL_LSB +: 3];
  assign burst_order_bit = mode_register[BT_BIT];
  assign latency_field = mode_register[CL_LSB +: 3];
  assign op_mode_bit_lo = mode_register[OM_LSB];
  assign op_mode_bit_hi = mode_register[OM_LSB+1];
  assign write_single_bit = mode_register[WS_BIT];
  assign mode_register_o = mode_register;

  // Normal mode and legal latency only
  assign mode_ok = ({op_mode_bit_hi, op_mode_bit_lo} == OM_NORMAL) &&
                   (latency_field == CL_1 || latency_field == CL_2 || latency_field == CL_3);

  always_comb
  begin
    case (burst_len_field)
      BL_1: burst_count = MASK_1;
      BL_2: burst_count = MASK_2;
      BL_4: burst_count = MASK_4;
      BL_8: burst_count = MASK_8;
      BL_PAGE: burst_count = MASK_PAGE;
      default: burst_count = MASK_1;
    endcase
  end

  assign start_mask = (go_wr && write_single_bit) ? MASK_1 : burst_count;

  assign cmd = sdmc_cmd_t'({ras_n_i, cas_n_i, we_n_i});
  assign bank_sel = {bank_select_hi_i, bank_select_lo_i};
  assign selected = !cs_n_i && (pwr == ST_RUN);
  assign run = selected && cke_i;
  assign go_act = run && (cmd == CMD_ACT);
  assign go_rd = run && (cmd == CMD_RD) && mode_ok;
  assign go_wr = run && (cmd == CMD_WR) && mode_ok;
  assign go_rw = go_rd || go_wr;
  assign go_bst = run && (cmd == CMD_BST);
  assign go_pre = run && (cmd == CMD_PRE);
  assign go_lmr = run && (cmd == CMD_LMR);
  assign go_ref = run && (cmd == CMD_REF);
  assign go_self = selected && !cke_i && (cmd == CMD_REF);

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      mode_register <= MODE_RESET;
    else if (go_lmr)
      mode_register <= addr_i;
  end

  // Gate low in self refresh until it rises again
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      pwr <= ST_RUN;
    else
      case (pwr)
        ST_RUN:
        begin
          if (go_self)
            pwr <= ST_SELF;
        end
        ST_SELF:
        begin
          if (cke_i)
            pwr <= ST_RUN;
        end
        default: pwr <= ST_RUN;
      endcase
  end
  assign self_refresh_o = pwr[1];

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      refresh_o <= 1'b0;
      refresh_row_o <= '0;
    end
    else
    begin
      refresh_o <= go_ref;
      if (go_ref)
        refresh_row_o <= ROW_W'(refresh_row_o + ROW_ONE);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      act_o <= 1'b0;
      act_bank_o <= '0;
      act_row_o <= '0;
    end
    else
    begin
      act_o <= go_act;
      if (go_act)
      begin
        act_bank_o <= bank_sel;
        act_row_o <= addr_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      pre_o <= 1'b0;
      pre_banks_o <= '0;
    end
    else
    begin
      pre_o <= go_pre;
      if (go_pre)
        pre_banks_o <= addr_i[AP_BIT] ? ALL_BANKS : (4'h1 << bank_sel);
    end
  end

  // Auto precharge closes the bank when a burst of length one to eight completes
  assign burst_end = bst_active && !go_rw && !go_bst && (bst_cnt == bst_mask) && (bst_mask != MASK_PAGE);
  assign ap_close = (go_rw && addr_i[AP_BIT] && start_mask == MASK_1) || (burst_end && bst_ap);
  assign ap_bank = go_rw ? bank_sel : bst_bank;

  always_comb
  begin
    next_bank_open = bank_open;
    if (ap_close)
      next_bank_open[ap_bank] = 1'b0;
    if (go_pre && addr_i[AP_BIT])
      next_bank_open = '0;
    else if (go_pre)
      next_bank_open[bank_sel] = 1'b0;
    if (go_act)
      next_bank_open[bank_sel] = 1'b1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      bank_open <= '0;
    else
      bank_open <= next_bank_open;
  end
  assign bank_open_o = bank_open;

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      bst_active <= 1'b0;
      bst_write <= 1'b0;
      bst_il <= 1'b0;
      bst_ap <= 1'b0;
      bst_bank <= '0;
      bst_base <= '0;
      bst_cnt <= '0;
      bst_mask <= MASK_1;
    end
    else if (go_rw)
    begin
      bst_active <= (start_mask != MASK_1);
      bst_write <= go_wr;
      bst_il <= burst_order_bit && (start_mask != MASK_PAGE);
      bst_ap <= addr_i[AP_BIT];
      bst_bank <= bank_sel;
      bst_base <= addr_i[COL_W-1:0];
      bst_cnt <= BEAT_ONE;
      bst_mask <= start_mask;
    end
    else if (go_bst || go_self || burst_end)
      bst_active <= 1'b0;
    else if (bst_active)
      bst_cnt <= 8'(bst_cnt + BEAT_ONE);
  end

  // Block from upper bits, start from lower
  always_comb
  begin
    beat_v = 1'b0;
    beat_wr = 1'b0;
    beat_bank = bst_bank;
    beat_col = burst_col(bst_base, bst_cnt, bst_mask, bst_il);
    if (go_rw)
    begin
      beat_v = 1'b1;
      beat_wr = go_wr;
      beat_bank = bank_sel;
      beat_col = addr_i[COL_W-1:0];
    end
    else if (bst_active && !go_bst && !go_self)
    begin
      beat_v = 1'b1;
      beat_wr = bst_write;
    end
  end

  // Write lanes masked in the same cycle
  sdmc_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(beat_v && beat_wr),
    .in_ready_o(fifo_ready),
    .in_data_i({beat_bank, beat_col, dqm_i, dq_i}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!array_hold_i),
    .out_data_o(fifo_out_data)
  );
  assign fifo_pop = fifo_out_valid && !array_hold_i;

  // Beat lost when the FIFO is full
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      wr_drop_o <= 1'b0;
    else
      wr_drop_o <= beat_v && beat_wr && !fifo_ready;
  end

  // High mask inhibits the lane write
  always_ff @(posedge sys_clk_i)
  begin
    if (fifo_pop)
      for (int l = 0; l < LANES; l++)
        if (!fifo_out_data[DQ_W+l])
          mem[fifo_out_data[FIFO_W-1 -: MEM_AW]][l*8 +: 8] <= fifo_out_data[l*8 +: 8];
  end

  // Read beat delay line for latency two and three
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      rd1_v <= 1'b0;
      rd2_v <= 1'b0;
      rd1_a <= '0;
      rd2_a <= '0;
    end
    else
    begin
      rd1_v <= beat_v && !beat_wr;
      rd1_a <= {beat_bank, beat_col};
      rd2_v <= rd1_v;
      rd2_a <= rd1_a;
    end
  end

  always_comb
  begin
    case (latency_field)
      CL_1:
      begin
        sel_v = beat_v && !beat_wr;
        sel_a = {beat_bank, beat_col};
      end
      CL_2:
      begin
        sel_v = rd1_v;
        sel_a = rd1_a;
      end
      default:
      begin
        sel_v = rd2_v;
        sel_a = rd2_a;
      end
    endcase
  end

  // Read mask applied two clocks late
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      out_v <= 1'b0;
      dq_o <= '0;
      dqm_q <= DQM_RESET;
      dq_oe_n_o <= OE_OFF;
    end
    else
    begin
      out_v <= sel_v;
      if (sel_v)
        dq_o <= mem[sel_a];
      dqm_q <= dqm_i;
      dq_oe_n_o <= ~{LANES{sel_v}} | dqm_q;
    end
  end

  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_read(logic [2:0] lat);
    go_rd && (latency_field == lat);
  endsequence

  property p_lat1;
    s_read(CL_1) |=> out_v;
  endproperty
  a_lat1: assert property (p_lat1) else $error("latency one read not driven next cycle");

  property p_lat3;
    s_read(CL_3) |-> ##3 out_v;
  endproperty
  a_lat3: assert property (p_lat3) else $error("latency three read not driven in time");

  property p_dqm;
    (|$past(dqm_i, 2)) |-> ((~dq_oe_n_o & $past(dqm_i, 2)) == '0);
  endproperty
  a_dqm: assert property (p_dqm) else $error("masked read lanes not floating");

  property p_lmr;
    go_lmr |=> (mode_register_o == $past(addr_i));
  endproperty
  a_lmr: assert property (p_lmr) else $error("mode register not loaded");

  property p_act;
    go_act |=> act_o && (act_row_o == $past(addr_i)) && (act_bank_o == $past(bank_sel));
  endproperty
  a_act: assert property (p_act) else $error("activate row or bank wrong");

  property p_pre_all;
    (go_pre && addr_i[AP_BIT]) |=> pre_o && (pre_banks_o == ALL_BANKS) && (bank_open_o == '0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all wrong");

  property p_pre_one;
    (go_pre && !addr_i[AP_BIT]) |=> (pre_banks_o == (4'h1 << $past(bank_sel)));
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("single bank precharge wrong");

  property p_self;
    go_self |=> self_refresh_o && !refresh_o;
  endproperty
  a_self: assert property (p_self) else $error("self refresh not entered");

  property p_ref;
    go_ref |=> refresh_o && (refresh_row_o == ROW_W'($past(refresh_row_o) + ROW_ONE));
  endproperty
  a_ref: assert property (p_ref) else $error("refresh counter not advanced");

  property p_cs;
    cs_n_i |=> !act_o && !pre_o && !refresh_o;
  endproperty
  a_cs: assert property (p_cs) else $error("command taken while deselected");

  property p_single;
    (go_wr && write_single_bit) |=> !bst_active;
  endproperty
  a_single: assert property (p_single) else $error("write burst despite single mode");

  property p_wrap;
    (beat_v && !go_rw) |-> ((beat_col & ~bst_mask) == (bst_base & ~bst_mask));
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst left its block");
endmodule

// file: logic/sdmc_fifo.sv
// Small shift-register FIFO with valid and ready on both sides
module sdmc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  logic [CW-1:0] count;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;
  logic [CW-1:0] slot;

  assign in_ready_o = (count != CW'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = store[0];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign slot = pop ? CW'(count - 1'b1) : count;

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      count <= '0;
    else
      count <= CW'(count + CW'(push) - CW'(pop));
  end

  // Head at entry zero, later entries move down on a pop
  always_ff @(posedge sys_clk_i)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (pop && (i + 1 < DEPTH))
        store[i] <= store[i+1];
      if (push && (slot == CW'(i)))
        store[i] <= in_data_i;
    end
  end
endmodule

// file: logic/sdmc_pkg.sv
// Shared constants and types for the SDRAM mode and command decoder
package sdmc_pkg;
  // Widths of the device
  localparam int unsigned MODE_W = 11;
  localparam int unsigned ROW_W = 11;
  localparam int unsigned COL_W = 8;
  localparam int unsigned DQ_W = 32;
  localparam int unsigned LANES = 4;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned MEM_AW = BANK_W + COL_W;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_W = MEM_AW + LANES + DQ_W;
  // Mode register field positions
  localparam int unsigned BL_LSB = 0;
  localparam int unsigned BT_BIT = 3;
  localparam int unsigned CL_LSB = 4;
  localparam int unsigned OM_LSB = 7;
  localparam int unsigned WS_BIT = 9;
  // Address bit selecting auto precharge or all banks
  localparam int unsigned AP_BIT = 10;
  // Burst length codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  // Column masks of the burst block
  localparam logic [7:0] MASK_1 = 8'h00;
  localparam logic [7:0] MASK_2 = 8'h01;
  localparam logic [7:0] MASK_4 = 8'h03;
  localparam logic [7:0] MASK_8 = 8'h07;
  localparam logic [7:0] MASK_PAGE = 8'hff;
  // Read latency codes and normal operating mode code
  localparam logic [2:0] CL_1 = 3'h1;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [1:0] OM_NORMAL = 2'h0;
  // Reset values, all-bank precharge mask and counter steps
  localparam logic [10:0] MODE_RESET = 11'h020;
  localparam logic [3:0] DQM_RESET = 4'hf;
  localparam logic [3:0] OE_OFF = 4'hf;
  localparam logic [3:0] ALL_BANKS = 4'hf;
  localparam logic [7:0] BEAT_ONE = 8'h01;
  localparam logic [10:0] ROW_ONE = 11'h001;
  // Commands as {row strobe, column strobe, write strobe}
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sdmc_cmd_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SELF = 2'b10
  } sdmc_pwr_t;
endpackage

// file: sim/sdmc_core_tb.sv
// Testbench of the SDRAM mode and command decoder
module sdmc_core_tb import sdmc_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, hold, cke, cs_n, wr_drop, act, pre, refr, selfr, il, ws;
  logic [2:0] cmd, cl;
  logic [10:0] addr, mode, act_row, ref_row, r;
  logic [1:0] bank, act_bank;
  logic [3:0] dqm, oe_n, pre_banks, bank_open;
  logic [31:0] dq, dq_rd;
  logic [7:0] mask, salt;
  logic [31:0] mem [int];
  int nb, keep, drops, n_errors, comparisons;
  sdmc_ctl sdmc_ctl_i (.sys_clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .addr_o(addr),
    .bank_o(bank), .dqm_o(dqm), .dq_o(dq));
  sdmc_core sdmc_core_i (.sys_clk_i(clk), .reset_n_i(rst_n), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .addr_i(addr), .bank_select_lo_i(bank[0]), .bank_select_hi_i(bank[1]),
    .dqm_i(dqm), .dq_i(dq), .dq_o(dq_rd), .dq_oe_n_o(oe_n), .array_hold_i(hold), .wr_drop_o(wr_drop),
    .mode_register_o(mode), .act_o(act), .act_bank_o(act_bank), .act_row_o(act_row), .pre_o(pre),
    .pre_banks_o(pre_banks), .bank_open_o(bank_open), .refresh_o(refr), .refresh_row_o(ref_row),
    .self_refresh_o(selfr));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
    if (wr_drop === 1'b1)
      drops++;
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Expected column of beat k
  function automatic logic [7:0] ord(input logic [7:0] b, input int k);
    logic [7:0] o;
    o = il ? (b ^ k[7:0]) : (b + k[7:0]);
    return (b & ~mask) | (o & mask);
  endfunction
  function automatic logic [31:0] dat(input logic [7:0] c);
    return {salt, c, ~c, c ^ 8'h5a};
  endfunction
  task automatic lmr(input logic [2:0] b, input logic t, input logic [2:0] c, input logic w);
    sdmc_ctl_i.lmr(b, t, c, w);
    sdmc_ctl_i.idle(1);
    chk(mode, {1'b0, w, 2'h0, c, t, b}); // fields
    case (b)
      BL_2: mask = MASK_2;
      BL_4: mask = MASK_4;
      BL_8: mask = MASK_8;
      BL_PAGE: mask = MASK_PAGE;
      default: mask = MASK_1;
    endcase
    nb = int'(mask) + 1;
    il = t;
    cl = c;
    ws = w;
    sdmc_ctl_i.cmd(CMD_ACT, 11'h5a5, 2'h2);
  endtask
  // Write burst; the model memory keeps unmasked, accepted beats
  task automatic wr(input logic [7:0] col, input logic [3:0] dm);
    logic [7:0] c;
    logic [31:0] d;
    salt++;
    for (int k = 0; k < nb; k++)
    begin
      c = ord(col, k);
      d = dat(c);
      sdmc_ctl_i.put(d, dm);
      if (k == 0)
      begin
        sdmc_ctl_i.cmd(CMD_WR, {3'h0, col}, 2'h2);
        sdmc_ctl_i.idle(0);
      end
      else
        tick();
      for (int l = 0; l < 4; l++)
        if (!dm[l] && k < keep && (k == 0 || !ws))
          mem[c][8*l+:8] = d[8*l+:8];
    end
    sdmc_ctl_i.put(~dq, 4'h0);
    repeat (5) tick();
  endtask
  task automatic rd(input logic [7:0] col, input logic [3:0] dm);
    logic [31:0] lm;
    lm = {{8{~dm[3]}}, {8{~dm[2]}}, {8{~dm[1]}}, {8{~dm[0]}}};
    sdmc_ctl_i.put(dq, dm);
    sdmc_ctl_i.idle(1);
    sdmc_ctl_i.cmd(CMD_RD, {3'h0, col}, 2'h2);
    sdmc_ctl_i.idle(0);
    repeat (cl - 1)
    begin
      chk(oe_n, OE_OFF); // not yet driving
      tick();
    end
    for (int k = 0; k < nb; k++)
    begin
      chk(oe_n, dm); // lanes
      chk(dq_rd & lm, mem[ord(col, k)] & lm); // order
      if (k == nb - 1 && mask == MASK_PAGE)
      begin
        sdmc_ctl_i.cmd(CMD_BST, 11'h000, 2'h0);
        sdmc_ctl_i.idle(0);
      end
      else
        tick();
    end
    chk(oe_n, OE_OFF); // burst ended
    sdmc_ctl_i.put(dq, 4'h0);
    tick();
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial
  begin
    rst_n = 1'b0;
    hold = 1'b0;
    keep = 256;
    salt = 8'h00;
    repeat (5) tick();
    chk(mode, MODE_RESET); // reset value
    chk({oe_n, bank_open, selfr}, {OE_OFF, 5'h00}); // idle
    rst_n = 1'b1;
    done("reset");
    tick();
    sdmc_ctl_i.cmd(CMD_ACT, 11'h5a5, 2'h2);
    sdmc_ctl_i.idle(0);
    chk({act, act_bank, act_row, bank_open}, {1'b1, 2'h2, 11'h5a5, 4'h4}); // row bank
    tick();
    chk(act, 1'b0); // pulse
    sdmc_ctl_i.pins(1'b1, 1'b1);
    sdmc_ctl_i.cmd(CMD_ACT, 11'h003, 2'h1);
    sdmc_ctl_i.idle(0);
    sdmc_ctl_i.pins(1'b1, 1'b0);
    chk({act, bank_open}, 5'h04); // deselected
    tick();
    done("activate");
    lmr(BL_8, 1'b0, CL_2, 1'b0);
    wr(8'h00, 4'h0);
    for (int c = 1; c <= 3; c++)
    begin
      lmr(BL_4, 1'b0, c[2:0], 1'b0);
      rd(8'h01, 4'h0);
    end
    done("latency");
    lmr(BL_8, 1'b1, CL_3, 1'b0);
    rd(8'h03, 4'h0);
    rd(8'h05, 4'h9);
    lmr(BL_2, 1'b1, CL_2, 1'b0);
    rd(8'h07, 4'h0);
    lmr(BL_1, 1'b1, CL_1, 1'b0);
    rd(8'h05, 4'h0);
    done("order");
    lmr(BL_4, 1'b0, CL_2, 1'b0);
    wr(8'h0e, 4'h0);
    rd(8'h0d, 4'h0);
    lmr(BL_2, 1'b0, CL_2, 1'b0);
    wr(8'h02, 4'h5);
    rd(8'h02, 4'h3);
    lmr(BL_4, 1'b0, CL_2, 1'b1);
    wr(8'h04, 4'h0);
    rd(8'h04, 4'h0);
    done("write");
    lmr(BL_8, 1'b0, CL_2, 1'b0);
    hold = 1'b1;
    keep = FIFO_DEPTH;
    wr(8'h10, 4'h0);
    chk(drops, 32'd4); // write path
    hold = 1'b0;
    keep = 256;
    repeat (6) tick();
    lmr(BL_4, 1'b0, CL_2, 1'b0);
    rd(8'h10, 4'h0);
    done("fifo");
    lmr(BL_PAGE, 1'b0, CL_1, 1'b0);
    nb = 4;
    rd(8'h0e, 4'h0); // page crosses blocks
    done("page");
    lmr(BL_2, 1'b0, CL_2, 1'b0);
    sdmc_ctl_i.cmd(CMD_RD, 11'h402, 2'h2);
    sdmc_ctl_i.idle(0);
    chk(bank_open, 4'h4); // open during burst
    tick();
    chk(bank_open, 4'h0); // auto precharge at end
    repeat (3) tick();
    done("auto precharge");
    sdmc_ctl_i.cmd(CMD_PRE, 11'h000, 2'h2);
    sdmc_ctl_i.idle(0);
    chk({pre, pre_banks, bank_open}, {1'b1, 4'h4, 4'h0}); // one bank
    tick();
    sdmc_ctl_i.cmd(CMD_ACT, 11'h001, 2'h1);
    sdmc_ctl_i.cmd(CMD_ACT, 11'h002, 2'h3);
    sdmc_ctl_i.cmd(CMD_PRE, 11'h400, 2'h1);
    sdmc_ctl_i.idle(0);
    chk({pre, pre_banks, bank_open}, {1'b1, ALL_BANKS, 4'h0}); // all banks
    tick();
    done("precharge");
    sdmc_ctl_i.cmd(CMD_REF, 11'h7ff, 2'h3);
    sdmc_ctl_i.idle(0);
    chk({refr, selfr}, 2'b10); // auto refresh
    r = ref_row;
    tick();
    sdmc_ctl_i.cmd(CMD_REF, 11'h000, 2'h0);
    sdmc_ctl_i.idle(0);
    chk({ref_row, act_row}, {r + ROW_ONE, 11'h002}); // own counter
    tick();
    sdmc_ctl_i.pins(1'b0, 1'b0);
    sdmc_ctl_i.cmd(CMD_REF, 11'h000, 2'h0);
    sdmc_ctl_i.idle(0);
    sdmc_ctl_i.pins(1'b1, 1'b0);
    chk({refr, selfr}, 2'b01); // self refresh
    tick();
    chk(selfr, 1'b0); // exit
    done("refresh");
    end_sim();
  end
endmodule

// file: sim/sdmc_ctl.sv
// Memory controller model driving command, address and data pins
module sdmc_ctl import sdmc_pkg::*; (
  // Clock
  input wire logic sys_clk_i,
  // Command pins
  output logic cke_o,
  output logic cs_n_o,
  output logic [2:0] cmd_o,
  output logic [ROW_W-1:0] addr_o,
  output logic [BANK_W-1:0] bank_o,
  // Data pins
  output logic [LANES-1:0] dqm_o,
  output logic [DQ_W-1:0] dq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    pins(1'b1, 1'b0);
    put(32'h0, 4'h0);
    drive(CMD_NOP, 11'h000, 2'h0);
  end
  task automatic drive(input sdmc_cmd_t c, input logic [ROW_W-1:0] a, input logic [BANK_W-1:0] b);
    cmd_o = c;
    addr_o = a;
    bank_o = b;
  endtask
  task automatic cmd(input sdmc_cmd_t c, input logic [ROW_W-1:0] a, input logic [BANK_W-1:0] b);
    drive(c, a, b);
    @(posedge sys_clk_i);
    #1;
  endtask
  // Address lines flipped once the command is taken
  task automatic idle(input int n);
    cmd_o = CMD_NOP;
    addr_o = ~addr_o;
    bank_o = ~bank_o;
    repeat (n)
    begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask
  // all banks idle before the load
  task automatic lmr(input logic [2:0] bl, input logic il, input logic [2:0] cl, input logic ws);
    cmd(CMD_PRE, 11'h400, 2'h0);
    cmd(CMD_LMR, {1'b0, ws, OM_NORMAL, cl, il, bl}, 2'h0);
  endtask
  task automatic put(input logic [DQ_W-1:0] d, input logic [LANES-1:0] m);
    dq_o = d;
    dqm_o = m;
  endtask
  task automatic pins(input logic ck, input logic cs);
    cke_o = ck;
    cs_n_o = cs;
  endtask
endmodule
